// ===== hw/pd_ctrl_pkg.sv
// shared constants, register map and types for the port control pair
// assumes a single 40 MHz clock on both ends
package pd_ctrl_pkg;

    // clock and timing
    localparam int CLK_NS = 25;
    localparam int SWAP_MIN_US = 60;
    localparam int SWAP_MAX_US = 120;
    // least time rounds up to whole cycles
    localparam int SWAP_CYCLES = (SWAP_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int WDOG_DEFAULT = 40000;
    localparam int HOLD_OFF_DEFAULT = 8000;

    // widths
    localparam int ALERT_W = 8;
    localparam int CC_W = 4;
    localparam int TYPE_W = 3;
    localparam int CNT_W = 8;
    localparam int LEN_W = 16;

    // termination and message checks
    localparam logic [CC_W-1:0] CC_TERM_OPEN = 4'hF;
    localparam logic [TYPE_W-1:0] TYPE_SOP_LIMIT = 3'h5;
    localparam logic [CNT_W-1:0] MIN_TX_BYTES = 8'h02;
    localparam logic [LEN_W-1:0] CHUNK_BYTES = 16'h001A;
    localparam logic [CNT_W-1:0] HDR_BYTES = 8'h04;
    localparam logic [CNT_W-1:0] MAX_TX_BYTES = 8'h1E;

    // register offsets of the manager end
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_SEND = 12'h004;
    localparam logic [11:0] REG_ALERT = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam logic [11:0] REG_CMD = 12'h010;

    // field positions
    localparam int CTRL_WDOG_BIT = 0;
    localparam int CTRL_CONTRACT_BIT = 1;
    localparam int CTRL_MASK_LSB = 8;
    localparam int SEND_EN_BIT = 0;
    localparam int SEND_TYPE_LSB = 4;
    localparam int SEND_LEN_LSB = 8;
    localparam int CMD_FRS_BIT = 0;
    localparam int CMD_FAULT_CLR_BIT = 1;
    localparam int CMD_RP_OK_BIT = 2;
    localparam int CMD_RP_BLOCK_BIT = 3;

    // sink send sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_SEND = 3'h4
    } sink_st_t;

endpackage

// ===== hw/pd_link_if.sv
// link between the port controller and its port manager
// assumes both ends share pclk; the bench resolves the cc wire
`timescale 1ns/1ps
`default_nettype none
interface pd_link_if;
    import pd_ctrl_pkg::*;
    // manager to controller
    logic host_access;
    logic wdog_enable;
    logic [ALERT_W-1:0] alert_mask;
    logic [ALERT_W-1:0] alert_clear;
    logic sink_write;
    logic sink_en;
    logic [TYPE_W-1:0] tx_packet_type;
    logic [CNT_W-1:0] tx_byte_count;
    logic rp_send_ok;
    logic frs_request;
    logic fault_clear;
    // controller to manager
    logic alert_interrupt_pin_n;
    logic [ALERT_W-1:0] alert_status;
    logic host_interface_fault;
    logic fault_irq;
    logic tx_discarded_alert;
    logic swap_active;
    logic sink_busy;
    logic cc_pull_o;
    logic cc_pull_oe;

    modport dev (
        input host_access, wdog_enable, alert_mask, alert_clear, sink_write,
        input sink_en, tx_packet_type, tx_byte_count, rp_send_ok, frs_request,
        input fault_clear,
        output alert_interrupt_pin_n, alert_status, host_interface_fault,
        output fault_irq, tx_discarded_alert, swap_active, sink_busy,
        output cc_pull_o, cc_pull_oe
    );
    modport mgr (
        output host_access, wdog_enable, alert_mask, alert_clear, sink_write,
        output sink_en, tx_packet_type, tx_byte_count, rp_send_ok, frs_request,
        output fault_clear,
        input alert_interrupt_pin_n, alert_status, host_interface_fault,
        input fault_irq, tx_discarded_alert, swap_active, sink_busy,
        input cc_pull_o, cc_pull_oe
    );
endinterface
`default_nettype wire

// ===== hw/pd_port_manager.sv
// port manager end: apb registers driving the controller link
// assumes pins attached, partner_rp_ok and rx_event are asynchronous
`timescale 1ns/1ps
`default_nettype none
module pd_port_manager #(
    parameter int HOLD_CYCLES = pd_ctrl_pkg::HOLD_OFF_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic attached,
    input wire logic partner_rp_ok,
    input wire logic rx_event,
    output logic rp_advert_ok,
    output logic source_ams_ok,
    output logic rx_status_alert,
    pd_link_if.mgr link
);
    import pd_ctrl_pkg::*;

    localparam int HD_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [HD_W-1:0] HD_LAST = HD_W'(HOLD_CYCLES);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic wdog_req;
        logic contract;
        logic [ALERT_W-1:0] mask;
        logic host_access;
        logic [ALERT_W-1:0] alert_clear;
        logic sink_write;
        logic sink_en;
        logic [TYPE_W-1:0] tx_type;
        logic [CNT_W-1:0] tx_cnt;
        logic frs_request;
        logic fault_clear;
        logic fault_seen;
        logic rx_status;
        logic [LEN_W-1:0] rem;
        logic rp_ok;
        logic [HD_W-1:0] hold_cnt;
        logic ams_ok;
        logic swap_prev;
    } mgr_state_t;

    mgr_state_t q;
    mgr_state_t d;
    logic access;
    logic mapped;
    logic [LEN_W-1:0] base;
    logic [LEN_W-1:0] chunk;

    assign access = psel && penable;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_SEND)
        || (paddr == REG_ALERT) || (paddr == REG_STATUS) || (paddr == REG_CMD);
    // length left to send, new length or the rest of the last
    assign base = (pwdata[SEND_LEN_LSB +: LEN_W] != '0)
        ? pwdata[SEND_LEN_LSB +: LEN_W] : q.rem;
    assign chunk = (base > CHUNK_BYTES) ? CHUNK_BYTES : base;

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.host_access = 1'b0;
        d.alert_clear = '0;
        d.sink_write = 1'b0;
        d.frs_request = 1'b0;
        d.fault_clear = 1'b0;

        // pin synchronisers, second stage is the only reader
        d.s1 = {rx_event, partner_rp_ok, attached};
        d.s2 = q.s1;

        // apb: one wait cycle, then the transfer completes
        d.pready = 1'b0;
        if (access && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = !mapped;
            d.prdata = '0;
            if (paddr == REG_CTRL) begin
                d.prdata[CTRL_WDOG_BIT] = q.wdog_req;
                d.prdata[CTRL_CONTRACT_BIT] = q.contract;
                d.prdata[CTRL_MASK_LSB +: ALERT_W] = q.mask;
            end else if (paddr == REG_ALERT) begin
                d.prdata[ALERT_W-1:0] = link.alert_status;
            end else if (paddr == REG_STATUS) begin
                d.prdata = {q.rem, link.alert_status, q.fault_seen, q.ams_ok,
                    q.rp_ok, q.rx_status, link.sink_busy, link.swap_active,
                    link.host_interface_fault, link.alert_interrupt_pin_n};
            end
        end

        // rx status, cleared by a send write or a discard
        if (link.tx_discarded_alert) begin
            d.rx_status = 1'b0;
        end

        // effects at the completing edge of a transfer
        if (access && q.pready) begin
            d.host_access = 1'b1;
            if (pwrite && mapped) begin
                unique case (paddr)
                    REG_CTRL: begin
                        d.wdog_req = pwdata[CTRL_WDOG_BIT];
                        d.contract = pwdata[CTRL_CONTRACT_BIT];
                        d.mask = pwdata[CTRL_MASK_LSB +: ALERT_W];
                    end
                    REG_SEND: begin
                        // buffers already loaded, request issued now
                        d.sink_write = 1'b1;
                        d.sink_en = pwdata[SEND_EN_BIT];
                        d.rx_status = 1'b0;
                        d.tx_type = pwdata[SEND_TYPE_LSB +: TYPE_W];
                        if (pwdata[SEND_EN_BIT]) begin
                            // nothing left to send gives an empty count
                            d.tx_cnt = (chunk == '0) ? '0 : CNT_W'(chunk) + HDR_BYTES;
                            d.rem = base - chunk;
                        end
                    end
                    REG_ALERT: d.alert_clear = pwdata[ALERT_W-1:0];
                    REG_CMD: begin
                        d.frs_request = pwdata[CMD_FRS_BIT] && q.contract;
                        d.fault_clear = pwdata[CMD_FAULT_CLR_BIT];
                        if (pwdata[CMD_FAULT_CLR_BIT]) begin
                            d.fault_seen = 1'b0;
                        end
                        if (pwdata[CMD_RP_OK_BIT]) begin
                            d.rp_ok = 1'b1;
                        end else if (pwdata[CMD_RP_BLOCK_BIT]) begin
                            d.rp_ok = 1'b0;
                        end
                    end
                    default: d.pslverr = 1'b0;
                endcase
            end
        end

        // sets after clears so an event is never lost
        if (q.s2[2]) begin
            d.rx_status = 1'b1;
        end
        if (link.fault_irq) begin
            d.fault_seen = 1'b1;
        end

        // swap finished: advertise send-allowed for the swap message
        d.swap_prev = link.swap_active;
        if (q.swap_prev && !link.swap_active) begin
            d.rp_ok = 1'b1;
        end

        // source hold-off after advertising the blocked level
        if (d.rp_ok) begin
            d.hold_cnt = '0;
            d.ams_ok = 1'b0;
        end else if (q.hold_cnt != HD_LAST) begin
            d.hold_cnt = q.hold_cnt + 1'b1;
        end else begin
            d.ams_ok = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign rp_advert_ok = q.rp_ok;
    assign source_ams_ok = q.ams_ok;
    assign rx_status_alert = q.rx_status;

    assign link.host_access = q.host_access;
    assign link.wdog_enable = q.wdog_req && q.s2[0];
    assign link.alert_mask = q.mask;
    assign link.alert_clear = q.alert_clear;
    assign link.sink_write = q.sink_write;
    assign link.sink_en = q.sink_en;
    assign link.tx_packet_type = q.tx_type;
    assign link.tx_byte_count = q.tx_cnt;
    assign link.rp_send_ok = q.s2[1];
    assign link.frs_request = q.frs_request;
    assign link.fault_clear = q.fault_clear;

endmodule
`default_nettype wire

// ===== hw/pd_port_watchdog_sinktx_frs.sv
// port controller end: watchdog, sink send gating, fast swap signal
// assumes the manager drives the link on pclk and pulses one cycle
`timescale 1ns/1ps
`default_nettype none
module pd_port_watchdog_sinktx_frs #(
    parameter int WDOG_CYCLES = pd_ctrl_pkg::WDOG_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    pd_link_if.dev link,
    input wire logic [pd_ctrl_pkg::ALERT_W-1:0] alert_events,
    input wire logic tx_done,
    input wire logic [pd_ctrl_pkg::CC_W-1:0] cc_term_req,
    input wire logic src_req,
    input wire logic snk_req,
    input wire logic vbus_safe0,
    output logic [pd_ctrl_pkg::CC_W-1:0] cc_term,
    output logic src_en,
    output logic snk_en,
    output logic vbus_discharge,
    output logic tx_start,
    output logic protocol_soft_reset
);
    import pd_ctrl_pkg::*;

    localparam int WD_W = $clog2(WDOG_CYCLES + 1);
    localparam int SW_W = $clog2(SWAP_CYCLES + 1);
    localparam logic [WD_W-1:0] WD_LAST = WD_W'(WDOG_CYCLES - 1);
    localparam logic [SW_W-1:0] SW_LAST = SW_W'(SWAP_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [ALERT_W-1:0] alert;
        logic irq_n;
        logic [WD_W-1:0] wd_cnt;
        logic torn_down;
        logic fault;
        logic fault_irq;
        sink_st_t st;
        logic busy;
        logic tx_start;
        logic txdisc;
        logic [SW_W-1:0] sw_cnt;
        logic swapping;
        logic prst;
        logic cc_o;
        logic cc_oe;
        logic [CC_W-1:0] cc_term;
        logic src_en;
        logic snk_en;
        logic discharge;
    } dev_state_t;

    dev_state_t q;
    dev_state_t d;
    logic unmasked;
    logic bad_type;
    logic too_long;

    // alerts that may interrupt the manager
    assign unmasked = |(q.alert & link.alert_mask);
    // short message of an ordinary packet type
    assign bad_type = (link.tx_packet_type < TYPE_SOP_LIMIT)
        && (link.tx_byte_count < MIN_TX_BYTES);
    // more than one chunk plus headers in one send
    assign too_long = link.tx_byte_count > MAX_TX_BYTES;

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.tx_start = 1'b0;
        d.prst = 1'b0;
        d.fault_irq = 1'b0;
        d.txdisc = 1'b0;
        d.cc_o = 1'b0;

        // sticky alerts, a new event beats its clear
        d.alert = (q.alert & ~link.alert_clear) | alert_events;
        d.irq_n = ~|(d.alert & link.alert_mask);

        // fault clear first so that a fresh fault wins
        if (link.fault_clear) begin
            d.fault = 1'b0;
            d.torn_down = 1'b0;
        end

        // watchdog on unserviced alerts
        if (!link.wdog_enable) begin
            d.wd_cnt = '0;
        end else if (link.host_access) begin
            d.wd_cnt = '0;
        end else if (unmasked || !q.irq_n) begin
            if (q.wd_cnt == WD_LAST) begin
                d.wd_cnt = '0;
                d.torn_down = 1'b1;
                d.fault = 1'b1;
                d.fault_irq = 1'b1;
            end else begin
                d.wd_cnt = q.wd_cnt + 1'b1;
            end
        end else begin
            d.wd_cnt = '0;
        end

        // sink send sequencer
        unique case (q.st)
            ST_IDLE: begin
                if (link.sink_write && link.sink_en) begin
                    if (bad_type || too_long) begin
                        d.fault = 1'b1;
                        d.fault_irq = 1'b1;
                    end else if (link.rp_send_ok) begin
                        d.st = ST_SEND;
                        d.tx_start = 1'b1;
                    end else begin
                        d.st = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (link.sink_write && !link.sink_en) begin
                    d.st = ST_IDLE;
                end else if (link.rp_send_ok) begin
                    d.st = ST_SEND;
                    d.tx_start = 1'b1;
                end
            end
            ST_SEND: begin
                if (link.sink_write) begin
                    d.fault = 1'b1;
                    d.fault_irq = 1'b1;
                end
                if (tx_done) begin
                    d.st = ST_IDLE;
                end
            end
        endcase

        // expiry drops any send in progress
        if (d.torn_down && !q.torn_down) begin
            d.st = ST_IDLE;
            d.tx_start = 1'b0;
        end

        // fast swap signal, a hard pull of cc to ground
        if (q.swapping) begin
            if (q.sw_cnt == SW_LAST) begin
                d.swapping = 1'b0;
                d.cc_oe = 1'b0;
            end else begin
                d.sw_cnt = q.sw_cnt + 1'b1;
            end
        end else if (link.frs_request) begin
            d.swapping = 1'b1;
            d.sw_cnt = '0;
            d.cc_oe = 1'b1;
            d.prst = 1'b1;
            if (q.st != ST_IDLE) begin
                d.txdisc = 1'b1;
            end
            d.st = ST_IDLE;
            d.tx_start = 1'b0;
        end

        // power path and termination, overridden after expiry
        d.cc_term = d.torn_down ? CC_TERM_OPEN : cc_term_req;
        d.src_en = src_req && !d.torn_down;
        d.snk_en = snk_req && !d.torn_down;
        d.discharge = d.torn_down && !vbus_safe0;
        d.busy = d.st != ST_IDLE;
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{
                alert: '0,
                irq_n: 1'b1,
                wd_cnt: '0,
                torn_down: 1'b0,
                fault: 1'b0,
                fault_irq: 1'b0,
                st: ST_IDLE,
                busy: 1'b0,
                tx_start: 1'b0,
                txdisc: 1'b0,
                sw_cnt: '0,
                swapping: 1'b0,
                prst: 1'b0,
                cc_o: 1'b0,
                cc_oe: 1'b0,
                cc_term: '0,
                src_en: 1'b0,
                snk_en: 1'b0,
                discharge: 1'b0
            };
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from the state register

    assign cc_term = q.cc_term;
    assign src_en = q.src_en;
    assign snk_en = q.snk_en;
    assign vbus_discharge = q.discharge;
    assign tx_start = q.tx_start;
    assign protocol_soft_reset = q.prst;

    // link answers to the manager
    assign link.alert_interrupt_pin_n = q.irq_n;
    assign link.alert_status = q.alert;
    assign link.host_interface_fault = q.fault;
    assign link.fault_irq = q.fault_irq;
    assign link.tx_discarded_alert = q.txdisc;
    assign link.swap_active = q.swapping;
    assign link.sink_busy = q.busy;
    assign link.cc_pull_o = q.cc_o;
    assign link.cc_pull_oe = q.cc_oe;

endmodule
`default_nettype wire

// ===== verif/pd_link_chk.sv
// checker for the signals of the controller link
// assumes one pclk domain; instantiated beside the link
`timescale 1ns/1ps
`default_nettype none
module pd_link_chk #(
    parameter int WDOG_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic host_access,
    input wire logic wdog_enable,
    input wire logic [pd_ctrl_pkg::ALERT_W-1:0] alert_mask,
    input wire logic [pd_ctrl_pkg::ALERT_W-1:0] alert_status,
    input wire logic alert_interrupt_pin_n,
    input wire logic host_interface_fault,
    input wire logic fault_clear,
    input wire logic sink_write,
    input wire logic frs_request,
    input wire logic swap_active,
    input wire logic sink_busy,
    input wire logic tx_discarded_alert,
    input wire logic cc_pull_o,
    input wire logic cc_pull_oe
);
    import pd_ctrl_pkg::*;
    int wd_q;
    int oe_q;
    logic pend;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // an unmasked alert or the pin keeps the watchdog busy
    assign pend = wdog_enable && ((|(alert_status & alert_mask)) || !alert_interrupt_pin_n);
    // shadow counts of pending cycles and pull-down cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_q <= 0;
            oe_q <= 0;
        end else begin
            wd_q <= (pend && !host_access) ? wd_q + 1 : 0;
            oe_q <= cc_pull_oe ? oe_q + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // the pin is a flop, so it follows a new mask one cycle later
    AST_PIN: assert property (alert_interrupt_pin_n
        == !(|(alert_status & $past(alert_mask))))
        else $error("pin level differs from masked alerts");
    AST_WDOG_EXPIRE: assert property (wd_q == WDOG_CYCLES - 1 |-> ##[0:3] host_interface_fault)
        else $error("watchdog did not expire in time");
    AST_WDOG_QUIET: assert property ($rose(host_interface_fault) && !$past(sink_write)
        |-> $past(wd_q) >= WDOG_CYCLES - 4)
        else $error("fault raised before watchdog ran out");
    AST_FAULT_HOLD: assert property ($fell(host_interface_fault) |-> $past(fault_clear))
        else $error("fault dropped without clear");
    AST_SWAP_TRIG: assert property (frs_request && !swap_active
        |=> swap_active && cc_pull_oe && !sink_busy)
        else $error("swap request not acted on");
    AST_DISCARD: assert property (frs_request && !swap_active && sink_busy
        |=> tx_discarded_alert)
        else $error("pending send not discarded");
    AST_SWAP_LEN: assert property ($fell(cc_pull_oe) |-> oe_q == SWAP_CYCLES)
        else $error("swap pull length wrong");
    AST_PULL_LOW: assert property (cc_pull_oe |-> !cc_pull_o)
        else $error("cc driven high while pulling");
    cover property ($fell(cc_pull_oe));
    cover property ($rose(host_interface_fault));
    cover property (tx_discarded_alert);
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// testbench joining manager and controller over the link
// assumes apb reads are checked against a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pd_ctrl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic attached, partner_rp_ok, rx_event, rp_advert_ok, source_ams_ok, rx_status_alert;
    logic [ALERT_W-1:0] alert_events;
    logic [CC_W-1:0] cc_term_req, cc_term;
    logic tx_done, src_req, snk_req, vbus_safe0, src_en, snk_en, vbus_discharge;
    logic tx_start, protocol_soft_reset, cc_wire;
    logic [31:0] exp_q[$], msk_q[$];
    int errors, compares, cyc, n_tx, n_rst;
    pd_link_if link();
    pd_port_manager #(.HOLD_CYCLES(10)) u_pd_port_manager (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .attached(attached),
        .partner_rp_ok(partner_rp_ok), .rx_event(rx_event), .rp_advert_ok(rp_advert_ok),
        .source_ams_ok(source_ams_ok), .rx_status_alert(rx_status_alert), .link(link));
    pd_port_watchdog_sinktx_frs #(.WDOG_CYCLES(20)) u_pd_port_watchdog_sinktx_frs (
        .pclk(pclk), .presetn(presetn), .link(link), .alert_events(alert_events),
        .tx_done(tx_done), .cc_term_req(cc_term_req), .src_req(src_req), .snk_req(snk_req),
        .vbus_safe0(vbus_safe0), .cc_term(cc_term), .src_en(src_en), .snk_en(snk_en),
        .vbus_discharge(vbus_discharge), .tx_start(tx_start),
        .protocol_soft_reset(protocol_soft_reset));
    pd_link_chk #(.WDOG_CYCLES(20)) u_pd_link_chk (.pclk(pclk), .presetn(presetn),
        .host_access(link.host_access), .wdog_enable(link.wdog_enable),
        .alert_mask(link.alert_mask), .alert_status(link.alert_status),
        .alert_interrupt_pin_n(link.alert_interrupt_pin_n),
        .host_interface_fault(link.host_interface_fault), .fault_clear(link.fault_clear),
        .sink_write(link.sink_write), .frs_request(link.frs_request),
        .swap_active(link.swap_active), .sink_busy(link.sink_busy),
        .tx_discarded_alert(link.tx_discarded_alert), .cc_pull_o(link.cc_pull_o),
        .cc_pull_oe(link.cc_pull_oe));
    // cc wire idles high through the pull-up
    assign cc_wire = link.cc_pull_oe ? link.cc_pull_o : 1'b1;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        repeat (2) @(posedge pclk);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pulse_done();
        @(posedge pclk);
        tx_done <= 1'b1;
        @(posedge pclk);
        tx_done <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // clock, read monitor, pulse counters, timeout
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            chk(prdata & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        if (tx_start === 1'b1) n_tx++;
        if (protocol_soft_reset === 1'b1) n_rst++;
        cyc++;
        if (cyc == 8000) begin
            errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, tx_done, rx_event} = '0;
        {partner_rp_ok, alert_events, cc_term_req, snk_req, vbus_safe0} = '0;
        {attached, src_req} = 2'b11;
        void'($urandom(32'h6578));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_STATUS, 32'h1, 32'hFF);
        rd(12'h100, 32'h0, 32'hFFFFFFFF);
        chk(pslverr, 32'h1);
        // held at blocked level, then aborted
        wr(REG_SEND, 32'h0851);
        rd(REG_STATUS, 32'h8, 32'h8);
        wr(REG_SEND, 32'h0);
        rd(REG_STATUS, 32'h0, 32'h8);
        chk(n_tx, 0);
        // allowed level sends at once, 40 bytes split
        partner_rp_ok <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(REG_SEND, 32'h2851);
        rd(REG_STATUS, 32'h000E0008, 32'hFFFF0008);
        chk(n_tx, 1);
        chk(link.tx_byte_count, 32'd30);
        wr(REG_SEND, 32'h0);
        rd(REG_STATUS, 32'hA, 32'hA);
        pulse_done();
        wr(REG_CMD, 32'h2);
        rd(REG_STATUS, 32'h0, 32'hA);
        // remainder waits for the allowed level
        partner_rp_ok <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(REG_SEND, 32'h51);
        repeat (5) @(posedge pclk);
        chk(n_tx, 1);
        partner_rp_ok <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(n_tx, 2);
        chk(link.tx_byte_count, 32'd18);
        pulse_done();
        // empty ordinary message is refused
        wr(REG_SEND, 32'h41);
        rd(REG_STATUS, 32'h2, 32'hA);
        wr(REG_CMD, 32'h2);
        // swap overrides a held send
        wr(REG_CTRL, 32'h2);
        partner_rp_ok <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(REG_SEND, 32'h0851);
        rx_event <= 1'b1;
        @(posedge pclk);
        rx_event <= 1'b0;
        rd(REG_STATUS, 32'h18, 32'h18);
        wr(REG_CMD, 32'h1);
        rd(REG_STATUS, 32'h4, 32'h1C);
        chk(n_rst, 1);
        chk(cc_wire, 1'b0);
        repeat (2450) @(posedge pclk);
        rd(REG_STATUS, 32'h20, 32'h24);
        wr(REG_CMD, 32'h8);
        repeat (20) @(posedge pclk);
        rd(REG_STATUS, 32'h40, 32'h60);
        // watchdog off, kept alive, then expiry
        cc_term_req <= CC_W'($urandom);
        alert_events <= ALERT_W'($urandom) | 8'h01;
        @(posedge pclk);
        alert_events <= 8'h00;
        wr(REG_CTRL, 32'hFF00);
        repeat (40) @(posedge pclk);
        rd(REG_STATUS, 32'h0, 32'h2);
        chk(cc_term, cc_term_req);
        wr(REG_CTRL, 32'hFF01);
        repeat (8) rd(REG_STATUS, 32'h0, 32'h2);
        repeat (30) @(posedge pclk);
        rd(REG_STATUS, 32'h2, 32'h2);
        chk(cc_term, CC_TERM_OPEN);
        chk({src_en, snk_en, vbus_discharge}, 3'b001);
        end_of_test();
    end
endmodule
`default_nettype wire
